// ==== hdl/isc_defs.vh ====
/*
 interpolation sequencing control constants: command codes, mode bit
 positions, status bit positions, range selects and stack counter values.
 assumes one 25 mhz clock and byte command codes from the host.
*/
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH
// command codes
`define ISC_CMD_STACK 8'h38
`define ISC_CMD_DEC_EN 8'h3b
`define ISC_CMD_DEC_DIS 8'h3c
`define ISC_CMD_INT_CLR 8'h3d
// interpolation mode register bit positions
`define ISC_MODE_VS_LO 8
`define ISC_MODE_VS_HI 9
`define ISC_MODE_CI_IE 14
`define ISC_MODE_BP_IE 15
// main status register bit positions
`define ISC_STAT_NEXT 9
`define ISC_STAT_SC_LO 13
`define ISC_STAT_SC_HI 14
// range select codes
`define ISC_RANGE_AX1 2'h0
`define ISC_RANGE_AX2 2'h1
`define ISC_RANGE_AX3 2'h2
// stack counter values
`define ISC_SC_ZERO 2'h0
`define ISC_SC_ONE 2'h1
`define ISC_SC_TWO 2'h2
`define ISC_SC_FULL 2'h3
`endif

// ==== hdl/isc_interp_seq_ctrl.v ====
/*
 interpolation sequencing control: bit-pattern refill interrupt, pattern
 stack counter, constant vector speed range select, continuous
 interpolation ready flag and interrupt, error hold and deceleration enable.
 assumes host command strobes are synchronous one-cycle pulses and the
 interrupt pin is resolved outside from its output and enable.
*/
// How it works
// - pattern irq low when counter goes two-to-one
// - stacking command releases pattern irq
// - clear command releases pattern irq
// - pattern end releases low irq
// - mode bits zero-one select vector speed
// - two-axis: one axis ax1, two ax2
// - three-axis: two axes ax2, three ax3
// - two-axis setting allowed during three-axis
// - high width fixed, only period grows
// - ready flag shows next command acceptance
// - ready only after start; reject otherwise
// - continuous irq low when ready rises
// - next command write returns irq high
// - clear command floats continuous irq
// - interpolation end disables continuous irq; pin floats unless pattern irq holds it low
// - error holds queued command until reload
// - enable and disable deceleration commands
// - enable ignored while drive runs
// - two-bit stack counter in status
`include "isc_defs.vh"
`default_nettype none
module isc_interp_seq_ctrl
(
   // clock, reset, enable
   input wire clock_in,
   input wire rst_b_in,
   input wire clk_en_in,
   // host command and mode
   input wire cmd_wr_in,
   input wire [7:0] cmd_code_in,
   input wire [15:0] interp_mode_register_in,
   input wire three_axis_in,
   // bit-pattern datapath
   input wire bp_data_wr_in,
   input wire bp_shift_in,
   input wire bp_active_in,
   // interpolation command and status
   input wire interp_cmd_wr_in,
   input wire node_start_in,
   input wire node_done_in,
   input wire interp_end_in,
   input wire error_in,
   input wire drive_busy_in,
   // axis step activity
   input wire [2:0] axis_step_in,
   // outputs
   output wire irq_out_n_o_out,
   output wire irq_out_n_oe_out,
   output reg [15:0] main_status_register_out,
   output reg [1:0] range_sel_out,
   output reg vector_speed_out,
   output reg decel_en_out,
   output reg cmd_accept_out,
   output reg cmd_exec_out,
   output wire bp_full_out
);

   // internal state
   reg [1:0] pattern_stack_counter_reg;
   reg [1:0] sc_next;
   reg bp_irq_reg;
   reg bp_irq_next;
   reg ci_irq_reg;
   reg ci_irq_next;
   reg ci_irq_en_reg;
   reg ci_irq_en_next;
   reg next_cmd_ready_reg;
   reg next_cmd_ready_next;
   reg queued_reg;
   reg queued_next;
   reg err_hold_reg;
   reg err_hold_next;
   reg ci_active_reg;
   reg ci_active_next;
   reg decel_en_next;
   reg [1:0] range_sel_next;

   // decoded strobes and counts
   wire clr_cmd;
   wire stack_cmd;
   wire dec_en_cmd;
   wire dec_dis_cmd;
   wire vs_mode;
   wire bp_irq_on;
   wire cmd_take;
   wire exec_go;
   wire [1:0] steps;
   wire [1:0] step_sum [0:3];
   genvar gi;

   assign clr_cmd = cmd_wr_in && (cmd_code_in == `ISC_CMD_INT_CLR);
   assign stack_cmd = cmd_wr_in && (cmd_code_in == `ISC_CMD_STACK);
   assign dec_en_cmd = cmd_wr_in && (cmd_code_in == `ISC_CMD_DEC_EN);
   assign dec_dis_cmd = cmd_wr_in && (cmd_code_in == `ISC_CMD_DEC_DIS);
   assign vs_mode = !interp_mode_register_in[`ISC_MODE_VS_HI] && interp_mode_register_in[`ISC_MODE_VS_LO];
   assign cmd_take = interp_cmd_wr_in && next_cmd_ready_reg && !err_hold_reg;
   assign exec_go = node_done_in && queued_reg && !err_hold_reg && !error_in;
   assign bp_irq_on = interp_mode_register_in[`ISC_MODE_BP_IE] && pattern_stack_counter_reg == `ISC_SC_TWO
      && sc_next == `ISC_SC_ONE;

   // count of axes stepping this period
   assign step_sum[0] = 2'h0;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_step
         // running sum, one axis per stage
         assign step_sum[gi + 1] = step_sum[gi] + {1'b0, axis_step_in[gi]};
      end
   endgenerate
   assign steps = step_sum[3];

   // open-drain pin: driven only low, floated otherwise
   assign bp_full_out = (pattern_stack_counter_reg == `ISC_SC_FULL);
   assign irq_out_n_o_out = 1'b0;
   assign irq_out_n_oe_out = bp_irq_reg | (ci_irq_reg & ci_irq_en_reg);

   // stack counter next value
   always @*
   begin
      sc_next = pattern_stack_counter_reg;
      if (bp_data_wr_in && !bp_full_out)
      begin
         if (!stack_cmd)
         begin
            sc_next = pattern_stack_counter_reg + 2'h1;
         end
      end
      else if (bp_shift_in && pattern_stack_counter_reg != `ISC_SC_ZERO)
      begin
         sc_next = pattern_stack_counter_reg - 2'h1;
      end
      if (!bp_active_in && !bp_data_wr_in)
      begin
         sc_next = `ISC_SC_ZERO;
      end
   end

   // pattern irq next value
   always @*
   begin
      bp_irq_next = bp_irq_reg;
      if (bp_irq_on)
      begin
         bp_irq_next = 1'b1;
      end
      else if (stack_cmd || clr_cmd)
      begin
         bp_irq_next = 1'b0;
      end
      else if (!bp_active_in)
      begin
         bp_irq_next = 1'b0;
      end
   end

   // continuous interpolation next values
   always @*
   begin
      next_cmd_ready_next = next_cmd_ready_reg;
      queued_next = queued_reg;
      err_hold_next = err_hold_reg;
      ci_active_next = ci_active_reg;
      ci_irq_next = ci_irq_reg;
      ci_irq_en_next = interp_mode_register_in[`ISC_MODE_CI_IE];
      if (node_start_in)
      begin
         ci_active_next = 1'b1;
         next_cmd_ready_next = 1'b1;
         if (interp_mode_register_in[`ISC_MODE_CI_IE] && !next_cmd_ready_reg)
         begin
            ci_irq_next = 1'b1;
         end
      end
      else if (cmd_take)
      begin
         next_cmd_ready_next = 1'b0;
         queued_next = 1'b1;
         ci_irq_next = 1'b0;
      end
      if (error_in && ci_active_reg)
      begin
         err_hold_next = 1'b1;
      end
      else if (interp_cmd_wr_in && err_hold_reg)
      begin
         err_hold_next = 1'b0;
         queued_next = 1'b1;
      end
      if (exec_go)
      begin
         queued_next = 1'b0;
      end
      if (clr_cmd)
      begin
         ci_irq_next = 1'b0;
      end
      if (interp_end_in)
      begin
         ci_irq_next = 1'b0;
         ci_irq_en_next = 1'b0;
         ci_active_next = 1'b0;
         next_cmd_ready_next = 1'b0;
      end
   end

   // deceleration enable next value
   always @*
   begin
      decel_en_next = decel_en_out;
      if (dec_en_cmd && !drive_busy_in)
      begin
         decel_en_next = 1'b1;
      end
      else if (dec_dis_cmd)
      begin
         decel_en_next = 1'b0;
      end
   end

   // vector speed range select next value
   always @*
   begin
      range_sel_next = `ISC_RANGE_AX1;
      if (vs_mode && steps == 2'h2)
      begin
         range_sel_next = `ISC_RANGE_AX2;
      end
      else if (vs_mode && steps == 2'h3 && !three_axis_in)
      begin
         range_sel_next = `ISC_RANGE_AX2;
      end
      else if (vs_mode && steps == 2'h3)
      begin
         range_sel_next = `ISC_RANGE_AX3;
      end
   end

   // stack counter and pattern irq registers
   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         pattern_stack_counter_reg <= `ISC_SC_ZERO;
         bp_irq_reg <= 1'b0;
      end
      else if (clk_en_in)
      begin
         pattern_stack_counter_reg <= sc_next;
         bp_irq_reg <= bp_irq_next;
      end
   end

   // continuous interpolation registers
   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         next_cmd_ready_reg <= 1'b0;
         queued_reg <= 1'b0;
         err_hold_reg <= 1'b0;
         ci_active_reg <= 1'b0;
         ci_irq_reg <= 1'b0;
         ci_irq_en_reg <= 1'b0;
      end
      else if (clk_en_in)
      begin
         next_cmd_ready_reg <= next_cmd_ready_next;
         queued_reg <= queued_next;
         err_hold_reg <= err_hold_next;
         ci_active_reg <= ci_active_next;
         ci_irq_reg <= ci_irq_next;
         ci_irq_en_reg <= ci_irq_en_next;
      end
   end

   // command accept and execute pulses
   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         cmd_accept_out <= 1'b0;
         cmd_exec_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         cmd_accept_out <= cmd_take;
         cmd_exec_out <= exec_go;
      end
   end

   // deceleration enable register
   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         decel_en_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         decel_en_out <= decel_en_next;
      end
   end

   // range select and vector speed registers; pulse high width kept by the pulse generator
   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         range_sel_out <= `ISC_RANGE_AX1;
         vector_speed_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         range_sel_out <= range_sel_next;
         vector_speed_out <= vs_mode;
      end
   end

   // main status register image
   always @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         main_status_register_out <= 16'h0000;
      end
      else if (clk_en_in)
      begin
         main_status_register_out <= 16'h0000;
         main_status_register_out[`ISC_STAT_NEXT] <= next_cmd_ready_reg;
         main_status_register_out[`ISC_STAT_SC_HI:`ISC_STAT_SC_LO] <= sc_next;
      end
   end
endmodule
`default_nettype wire

// ==== sim/isc_interp_seq_ctrl_chk.sv ====
/* checker: interrupt, ready, counter and deceleration relations.
   assumes checks pause while clk_en_in is low. */
`default_nettype none
module isc_chk(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic clk_en_in,
   // inputs watched
   input wire logic cmd_wr_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [15:0] interp_mode_register_in,
   input wire logic bp_data_wr_in,
   input wire logic bp_shift_in,
   input wire logic bp_active_in,
   input wire logic interp_cmd_wr_in,
   input wire logic node_start_in,
   input wire logic interp_end_in,
   input wire logic drive_busy_in,
   // outputs watched
   input wire logic irq_out_n_oe_out,
   input wire logic [15:0] main_status_register_out,
   input wire logic decel_en_out,
   input wire logic cmd_accept_out
);
   wire [1:0] sc = main_status_register_out[14:13];
   wire rdy = main_status_register_out[9];
   wire clr = cmd_wr_in && cmd_code_in == 8'h3d;
   wire den = cmd_wr_in && cmd_code_in == 8'h3b;
   wire bps = bp_active_in && interp_mode_register_in[15] && bp_shift_in && !bp_data_wr_in && sc == 2'h2;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in || !clk_en_in);
   sequence s_ci_up; irq_out_n_oe_out ##1 rdy; endsequence
   property p_bp_irq; bps |=> irq_out_n_oe_out; endproperty
   a_bp_irq: assert property (p_bp_irq) else $error("pattern irq missing");
   property p_clr; clr && !bps |=> !irq_out_n_oe_out; endproperty
   a_clr: assert property (p_clr) else $error("clear left irq low");
   property p_ci_irq; node_start_in && interp_mode_register_in[14] && !clr && !interp_end_in |=> s_ci_up; endproperty
   a_ci_irq: assert property (p_ci_irq) else $error("ready irq missing");
   property p_ci_ack;
      rdy && interp_cmd_wr_in && !$past(interp_cmd_wr_in) && !node_start_in && !bp_active_in
      |=> cmd_accept_out && !irq_out_n_oe_out;
   endproperty
   a_ci_ack: assert property (p_ci_ack) else $error("next command not taken");
   property p_no_acc; interp_cmd_wr_in && !rdy && !$past(node_start_in) |=> !cmd_accept_out; endproperty
   a_no_acc: assert property (p_no_acc) else $error("command taken while not ready");
   property p_dec_on; den && !drive_busy_in |=> decel_en_out; endproperty
   a_dec_on: assert property (p_dec_on) else $error("decel not enabled");
   property p_dec_busy; den && drive_busy_in |=> $stable(decel_en_out); endproperty
   a_dec_busy: assert property (p_dec_busy) else $error("decel changed while busy");
   property p_sc_up; bp_active_in && bp_data_wr_in && !bp_shift_in && sc == 2'h1 |=> sc == 2'h2; endproperty
   a_sc_up: assert property (p_sc_up) else $error("stack count not raised");
endmodule
bind isc_interp_seq_ctrl isc_chk chk(.*);
`default_nettype wire

// ==== sim/isc_host_model.sv ====
/* host model: command and interpolation write strobes.
   assumes the bench calls its tasks. */
`default_nettype none
module isc_host_model(
   input wire logic clk_in,
   output logic wr_out = 1'b0,
   output logic [7:0] code_out = 8'h00,
   output logic iwr_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   task cmd(input logic [7:0] c);
      @(posedge clk_in);
      #1 wr_out = 1'b1;
      code_out = c;
      @(posedge clk_in);
      #1 wr_out = 1'b0;
      code_out = ~c;
   endtask
   // next command write strobe, sent without checking ready or error state
   task load;
      @(posedge clk_in);
      #1 iwr_out = 1'b1;
      @(posedge clk_in);
      #1 iwr_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== sim/isc_interp_seq_ctrl_tb.sv ====
/* bench: range select rows, then irq, ready, error, decel cases.
   assumes the host model and a single clock. */
`default_nettype none
module isc_interp_seq_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_b = 0, three = 0, bwr = 0, bsh = 0, bact = 0;
   logic nst = 0, ndn = 0, iend = 0, err = 0, busy = 0, en = 1;
   logic [2:0] stp = 0;
   logic [15:0] mode = 0;
   wire oe, od, acc, ex, dec, vs, full, wr, iwr;
   wire [1:0] rs;
   wire [7:0] code;
   wire [15:0] st;
   int fails = 0, tests_run = 0;
   logic [8:0] rows [7] = '{9'b001001001, 9'b001011011, 9'b101011011, 9'b101111101,
      9'b001111011, 9'b000011000, 9'b011011000};
   always #20 clk = ~clk;
   isc_host_model h(.clk_in(clk), .wr_out(wr), .code_out(code), .iwr_out(iwr));
   isc_interp_seq_ctrl dut(.clock_in(clk), .rst_b_in(rst_b), .clk_en_in(en), .cmd_wr_in(wr),
      .cmd_code_in(code), .interp_mode_register_in(mode), .three_axis_in(three), .bp_data_wr_in(bwr),
      .bp_shift_in(bsh), .bp_active_in(bact), .interp_cmd_wr_in(iwr), .node_start_in(nst),
      .node_done_in(ndn), .interp_end_in(iend), .error_in(err), .drive_busy_in(busy),
      .axis_step_in(stp), .irq_out_n_o_out(od), .irq_out_n_oe_out(oe), .main_status_register_out(st),
      .range_sel_out(rs), .vector_speed_out(vs), .decel_en_out(dec), .cmd_accept_out(acc),
      .cmd_exec_out(ex), .bp_full_out(full));
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         fails++;
      end
   endtask
   task automatic pul(ref logic s);
      @(posedge clk);
      #1 s = 1;
      @(posedge clk);
      #1 s = 0;
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #20000 fails++;
      final_report;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      #1 rst_b = 1;
      chk("decel", 0, dec);
      chk("status", 0, st);
      chk("od", 0, od);
      foreach (rows[i])
      begin
         {three, mode[9:8], stp} = rows[i][8:3];
         repeat (2) @(posedge clk);
         #1 chk("vs", rows[i][0], vs);
         chk("range", rows[i][2:1], rs);
      end
      bact = 1;
      mode = 16'h8000;
      pul(bwr);
      pul(bwr);
      chk("sc", 16'h4000, st);
      pul(bsh);
      chk("irq", 1, oe);
      h.cmd(8'h38);
      chk("irq", 0, oe);
      pul(bwr);
      pul(bsh);
      h.cmd(8'h3d);
      chk("irq", 0, oe);
      pul(bwr);
      pul(bsh);
      bact = 0;
      #40 chk("irq", 0, oe);
      mode = 16'h4000;
      pul(nst);
      chk("irq", 1, oe);
      #40 chk("ready", 16'h0200, st);
      h.load;
      chk("acc", 1, acc);
      chk("irq", 0, oe);
      h.load;
      chk("acc", 0, acc);
      pul(ndn);
      chk("exec", 1, ex);
      pul(nst);
      h.cmd(8'h3d);
      chk("irq", 0, oe);
      h.load;
      pul(err);
      pul(ndn);
      chk("exec", 0, ex);
      h.load;
      pul(ndn);
      chk("exec", 1, ex);
      pul(nst);
      pul(iend);
      chk("irq", 0, oe);
      busy = 1;
      h.cmd(8'h3b);
      chk("decel", 0, dec);
      busy = 0;
      h.cmd(8'h3b);
      chk("decel", 1, dec);
      h.cmd(8'h3c);
      chk("decel", 0, dec);
      en = 0;
      h.cmd(8'h3b);
      chk("freeze", 0, dec);
      en = 1;
      h.cmd(8'h3b);
      @(posedge clk);
      #1 rst_b = 0;
      @(posedge clk);
      #1 rst_b = 1;
      chk("decel", 0, dec);
      chk("status", 0, st);
      bact = 1;
      repeat (4) pul(bwr);
      chk("full", 1, full);
      chk("sc", 16'h6000, st);
      bact = 0;
      final_report;
   end
endmodule
`default_nettype wire
